// >>> tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
    logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic chatter = 0, core_sout = 1, core_irtx = 0, err, sout, irtx;
    logic [5:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, dtr_n, rts_n, core_sin, core_irrx;
    logic extended_mode, loopback, baud_tick;
    logic [15:0] divisor;
    logic [7:0] line_control, fifo_control;
    uebc_pkg::uebc_levels_s levels = '0;
    uebc_pkg::uebc_pins_s pins;
    uebc_pkg::uebc_modem_s modem;
    int n_fail = 0, samples_checked = 0, cycles = 0;

    // identity values are arbitrary
    uebc_top #(.MODULE_TYPE(4'h9), .REVISION(4'h3)) dut (
        .clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pins_in(pins), .core_sout(core_sout), .core_irtx(core_irtx),
        .levels(levels), .sout(sout), .irtx(irtx), .dtr_n(dtr_n),
        .rts_n(rts_n), .core_sin(core_sin), .core_irrx(core_irrx),
        .modem(modem), .extended_mode(extended_mode), .loopback(loopback),
        .divisor(divisor), .baud_tick(baud_tick),
        .line_control(line_control), .fifo_control(fifo_control)
    );
    uebc_line_model lm (.clk(clk), .rstn(rstn), .chatter(chatter),
        .pins(pins));

    initial begin
        forever #2 clk = ~clk;
    end

    task close_out;
        if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // hang guard, the full run needs well under 2000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles > 6000) begin
            n_fail++;
            close_out();
        end
    end

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one apb transfer; entered just after a rising edge
    task apb(input logic w, input logic [3:0] i, input logic [7:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task wr(input logic [3:0] i, input logic [7:0] d);
        apb(1'b1, i, d);
    endtask

    task rdc(input string nm, input logic [3:0] i, input logic [31:0] exp);
        apb(1'b0, i, 8'h00);
        chk(nm, rd, exp);
    endtask

    task t_reset;
        rdc("ext_one", uebc_pkg::IDX_EXT_ONE, 32'h0);
        rdc("ext_two", uebc_pkg::IDX_EXT_TWO, 32'h0);
        rdc("identity", uebc_pkg::IDX_MODULE_IDENTITY, 32'h93);
    endtask

    // reserved bits drop, stored bits read back
    task t_reserved;
        wr(uebc_pkg::IDX_EXT_ONE, 8'hff);
        chk("ext_mode", {31'h0, extended_mode}, 32'h1);
        rdc("ext_one_rb", uebc_pkg::IDX_EXT_ONE, 32'hb1);
        wr(uebc_pkg::IDX_EXT_ONE, 8'h00);
        wr(uebc_pkg::IDX_EXT_TWO, 8'h7f);
        rdc("ext_two_rb", uebc_pkg::IDX_EXT_TWO, 32'h30);
        wr(uebc_pkg::IDX_EXT_TWO, 8'h00);
        wr(uebc_pkg::IDX_BANK2_RSVD, 8'hff);
        rdc("bank2_rsvd", uebc_pkg::IDX_BANK2_RSVD, 32'h0);
    endtask

    // counts move freely, so take the three-read vote
    task t_levels;
        logic [31:0] a, b;
        levels <= {5'h1f, 5'h0a};
        for (int j = 0; j < 2; j++) begin
            apb(1'b0, j ? uebc_pkg::IDX_RX_LEVEL : uebc_pkg::IDX_TX_LEVEL, '0);
            a = rd;
            apb(1'b0, j ? uebc_pkg::IDX_RX_LEVEL : uebc_pkg::IDX_TX_LEVEL, '0);
            b = rd;
            apb(1'b0, j ? uebc_pkg::IDX_RX_LEVEL : uebc_pkg::IDX_TX_LEVEL, '0);
            chk("level", (a === b) ? b : rd, j ? 32'h0a : 32'h1f);
        end
    endtask

    task t_shadows;
        wr(uebc_pkg::IDX_LINE_CONTROL, 8'h5b);
        wr(uebc_pkg::IDX_LC_SHADOW, 8'h00);
        rdc("lc_shadow", uebc_pkg::IDX_LC_SHADOW, 32'h5b);
        wr(uebc_pkg::IDX_FIFO_CONTROL, 8'hc7);
        rdc("fc_shadow", uebc_pkg::IDX_FC_SHADOW, 32'hc7);
        rdc("fc_wo", uebc_pkg::IDX_FIFO_CONTROL, 32'h0);
        rdc("unmapped", 4'hd, 32'h0);
        chk("slverr", {31'h0, err}, 32'h1);
    endtask

    // far side chatters throughout, so no pin may leak in
    task t_loop;
        chatter <= 1'b1;
        core_sout <= 1'b0;
        core_irtx <= 1'b1;
        wr(uebc_pkg::IDX_MODEM_CONTROL, 8'h13);
        repeat (8) @(posedge clk);
        chk("loop", {31'h0, loopback}, 32'h1);
        chk("tx_hold", {30'h0, sout, irtx}, 32'h2);
        chk("rx_path", {30'h0, core_sin, core_irrx}, 32'h1);
        chk("modem", {28'h0, modem}, 32'h3);
        wr(uebc_pkg::IDX_EXT_ONE, 8'h11);
        repeat (8) @(posedge clk);
        chk("modem_ext", {28'h0, modem}, 32'hf);
        wr(uebc_pkg::IDX_EXT_ONE, 8'h31);
        repeat (8) @(posedge clk);
        chk("tx_on", {30'h0, sout, irtx}, 32'h1);
        core_sout <= 1'b1;
        core_irtx <= 1'b0;
        repeat (4) @(posedge clk);
        chk("tx_rx", {28'h0, sout, irtx, core_sin, core_irrx}, 32'ha);
        wr(uebc_pkg::IDX_EXT_ONE, 8'h00);
        repeat (8) @(posedge clk);
        chk("loop_off", {31'h0, loopback}, 32'h0);
        chk("mc_out", {30'h0, dtr_n, rts_n}, 32'h0);
        chk("glitch", {26'h0, modem, core_sin, core_irrx}, 32'h3);
        chatter <= 1'b0;
    endtask

    // window of 104 cycles is a whole number of prescaler periods
    task t_presc;
        int n;
        for (int s = 0; s < 4; s++) begin
            wr(uebc_pkg::IDX_EXT_TWO, {2'b00, 2'(s), 4'h0});
            repeat (26) @(posedge clk);
            n = 0;
            repeat (104) begin
                @(posedge clk);
                n += int'(baud_tick);
            end
            chk("ticks", n, s == 1 ? 64 : s == 3 ? 104 : 8);
        end
        wr(uebc_pkg::IDX_EXT_TWO, 8'h00);
    endtask

    // one pulse per 13 cycles gives two dtr edges per period
    task t_baud_test;
        int n;
        logic prev;
        wr(uebc_pkg::IDX_EXT_ONE, 8'h80);
        repeat (26) @(posedge clk);
        n = 0;
        prev = dtr_n;
        repeat (104) begin
            @(posedge clk);
            n += int'(dtr_n !== prev);
            prev = dtr_n;
        end
        chk("baud_test", 32'(n), 32'd16);
        wr(uebc_pkg::IDX_EXT_ONE, 8'h00);
    endtask

    // lock is cleared again before extended mode is used
    task t_lock;
        wr(uebc_pkg::IDX_DIV_LOW, 8'h34);
        chk("div", {16'h0, divisor}, 32'h34);
        wr(uebc_pkg::IDX_EXT_TWO, 8'h80);
        wr(uebc_pkg::IDX_DIV_LOW, 8'h77);
        wr(uebc_pkg::IDX_DIV_HIGH, 8'h12);
        chk("div_locked", {16'h0, divisor}, 32'h34);
        rdc("scratch", uebc_pkg::IDX_DIV_LOW, 32'h77);
        wr(uebc_pkg::IDX_EXT_TWO, 8'h00);
        rdc("div_low", uebc_pkg::IDX_DIV_LOW, 32'h34);
        wr(uebc_pkg::IDX_EXT_ONE, 8'hb1);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        chk("div_rst", {16'h0, divisor}, 32'h1);
        rdc("ext_one_rst", uebc_pkg::IDX_EXT_ONE, 32'h0);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_reserved();
        t_levels();
        t_shadows();
        t_loop();
        t_presc();
        t_baud_test();
        t_lock();
        close_out();
    end
endmodule

`default_nettype wire

// >>> uebc_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none

module uebc_chk #(
    parameter logic [3:0] MODULE_TYPE = uebc_pkg::MODULE_TYPE_DEF,
    parameter logic [3:0] REVISION = uebc_pkg::REVISION_DEF
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [uebc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire uebc_pkg::uebc_levels_s levels,
    input wire logic core_sout,
    input wire logic core_irtx,
    input wire logic core_sin,
    input wire logic core_irrx,
    input wire logic extended_mode,
    input wire logic loopback,
    input wire logic [15:0] divisor,
    input wire logic [7:0] line_control,
    input wire logic [7:0] fifo_control
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // setup cycle decoded, then the committing access edge
    sequence s_setup(logic [3:0] i);
        psel && !penable && paddr[5:2] == i;
    endsequence
    sequence s_wr(logic [3:0] i);
        psel && penable && pready && pwrite && pstrb[0] && paddr[5:2] == i;
    endsequence

    a_ack_one_wait: assert property (psel && !penable |=> pready)
        else $error("no answer one cycle after setup");
    a_reset_clears: assert property ($rose(rstn) |->
        !extended_mode && !loopback && divisor == 16'h0001)
        else $error("state not cleared by reset");
    a_ident_read: assert property (
        s_setup(uebc_pkg::IDX_MODULE_IDENTITY)
        |=> prdata == {24'h0, MODULE_TYPE, REVISION})
        else $error("identity read wrong");
    a_rsvd_read: assert property (
        s_setup(uebc_pkg::IDX_BANK2_RSVD) |=> prdata == 32'h0)
        else $error("reserved register not zero");
    a_tx_level: assert property (s_setup(uebc_pkg::IDX_TX_LEVEL)
        |=> prdata == {27'h0, $past(levels.tx_count)})
        else $error("transmit level read wrong");
    a_rx_level: assert property (s_setup(uebc_pkg::IDX_RX_LEVEL)
        |=> prdata == {27'h0, $past(levels.rx_count)})
        else $error("receive level read wrong");
    a_lc_shadow: assert property (s_setup(uebc_pkg::IDX_LC_SHADOW)
        |=> prdata == {24'h0, $past(line_control)})
        else $error("line control shadow wrong");
    a_fc_shadow: assert property (s_setup(uebc_pkg::IDX_FC_SHADOW)
        |=> prdata == {24'h0, $past(fifo_control)})
        else $error("fifo control shadow wrong");
    a_ext_select: assert property (s_wr(uebc_pkg::IDX_EXT_ONE)
        |=> extended_mode == $past(pwdata[0]))
        else $error("extended select not taken");
    a_loop_shared: assert property (
        s_wr(uebc_pkg::IDX_MODEM_CONTROL) |=> loopback == $past(pwdata[4]))
        else $error("modem control loop bit not shared");
    a_loop_rx_path: assert property (loopback && $past(loopback)
        |-> core_sin == $past(core_sout) && core_irrx == $past(core_irtx))
        else $error("receiver not fed from transmitter");
    a_unmapped_err: assert property (s_setup(4'hd)
        |=> pslverr && prdata == 32'h0)
        else $error("unmapped index not refused");
endmodule

bind uebc_top uebc_chk #(.MODULE_TYPE(MODULE_TYPE), .REVISION(REVISION)) u_chk (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .levels(levels),
    .core_sout(core_sout), .core_irtx(core_irtx), .core_sin(core_sin),
    .core_irrx(core_irrx), .extended_mode(extended_mode),
    .loopback(loopback), .divisor(divisor), .line_control(line_control),
    .fifo_control(fifo_control)
);

`default_nettype wire

// >>> uebc_line_model.sv
`timescale 1ns/100ps
`default_nettype none

module uebc_line_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic chatter,
    output var uebc_pkg::uebc_pins_s pins
);
    // idle lines sit high; chatter flips every line each cycle so that
    // a cut path that still leaks shows up as a wrong level
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pins <= uebc_pkg::PINS_IDLE;
        end else if (chatter) begin
            pins <= ~pins;
        end else begin
            pins <= uebc_pkg::PINS_IDLE;
        end
    end
endmodule

`default_nettype wire

// >>> uebc_pkg.sv
package uebc_pkg;

    // register indices, byte address is four times the index
    localparam logic [3:0] IDX_MODULE_IDENTITY = 4'h0;
    localparam logic [3:0] IDX_LC_SHADOW = 4'h1;
    localparam logic [3:0] IDX_FC_SHADOW = 4'h2;
    localparam logic [3:0] IDX_LINE_CONTROL = 4'h3;
    localparam logic [3:0] IDX_EXT_ONE = 4'h4;
    localparam logic [3:0] IDX_BANK2_RSVD = 4'h5;
    localparam logic [3:0] IDX_EXT_TWO = 4'h6;
    localparam logic [3:0] IDX_TX_LEVEL = 4'h7;
    localparam logic [3:0] IDX_RX_LEVEL = 4'h8;
    localparam logic [3:0] IDX_MODEM_CONTROL = 4'h9;
    localparam logic [3:0] IDX_FIFO_CONTROL = 4'ha;
    localparam logic [3:0] IDX_DIV_LOW = 4'hb;
    localparam logic [3:0] IDX_DIV_HIGH = 4'hc;

    localparam int unsigned ADDR_W = 6;
    localparam int unsigned IDX_LSB = 2;
    localparam int unsigned COUNT_W = 5;

    // extended_control_one fields
    localparam int unsigned EXT_SEL_BIT = 0;
    localparam int unsigned LOOP_BIT = 4;
    localparam int unsigned TDL_BIT = 5;
    localparam int unsigned BAUD_TEST_BIT = 7;
    localparam logic [7:0] EXT_ONE_STORE_MASK = 8'ha1;

    // extended_control_two fields
    localparam int unsigned PRESC_LSB = 4;
    localparam int unsigned LOCK_BIT = 7;
    localparam logic [7:0] EXT_TWO_STORE_MASK = 8'hb0;

    // modem_control low bits
    localparam int unsigned MC_DTR_BIT = 0;
    localparam int unsigned MC_RTS_BIT = 1;
    localparam int unsigned MC_OUT1_BIT = 2;
    localparam int unsigned MC_OUT2_BIT = 3;

    // reset values
    localparam logic [7:0] EXT_ONE_RST = 8'h00;
    localparam logic [7:0] EXT_TWO_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [3:0] MC_LOW_RST = 4'h0;
    localparam logic [15:0] DIVISOR_RST = 16'h0001;
    localparam logic [5:0] PINS_IDLE = 6'h3f;

    // identity, values are arbitrary
    localparam logic [3:0] MODULE_TYPE_DEF = 4'h5;
    localparam logic [3:0] REVISION_DEF = 4'h1;

    // prescaler selects and their ratio as numerator over modulus
    localparam logic [1:0] PRESC_DIV13 = 2'b00;
    localparam logic [1:0] PRESC_DIV1P625 = 2'b01;
    localparam logic [1:0] PRESC_RSVD = 2'b10;
    localparam logic [1:0] PRESC_DIV1 = 2'b11;
    localparam logic [4:0] PRESC_MOD_13 = 5'h0d;
    localparam logic [4:0] PRESC_MOD_1 = 5'h01;
    localparam logic [4:0] PRESC_NUM_FRAC = 5'h08;
    localparam logic [4:0] PRESC_NUM_1 = 5'h01;

    typedef struct packed {
        logic dcd;
        logic ri;
        logic dsr;
        logic cts;
    } uebc_modem_s;

    typedef struct packed {
        logic [COUNT_W-1:0] tx_count;
        logic [COUNT_W-1:0] rx_count;
    } uebc_levels_s;

    typedef struct packed {
        logic sin;
        logic irrx;
        logic dsr_n;
        logic cts_n;
        logic ri_n;
        logic dcd_n;
    } uebc_pins_s;

endpackage

// >>> uebc_prescaler.sv
`timescale 1ns/100ps
`default_nettype none

module uebc_prescaler (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] sel,
    output logic tick
);

    typedef struct packed {
        logic [4:0] acc;
        logic tick;
    } uebc_presc_state_s;

    uebc_presc_state_s q;
    uebc_presc_state_s d;
    logic [4:0] num;
    logic [4:0] modulus;
    logic [5:0] sum;

    // fractional divider: adds num per cycle, ticks on each wrap
    always_comb begin
        d = q;
        case (sel)
            uebc_pkg::PRESC_DIV13: begin
                num = uebc_pkg::PRESC_NUM_1;
                modulus = uebc_pkg::PRESC_MOD_13;
            end
            uebc_pkg::PRESC_DIV1P625: begin
                num = uebc_pkg::PRESC_NUM_FRAC;
                modulus = uebc_pkg::PRESC_MOD_13;
            end
            uebc_pkg::PRESC_DIV1: begin
                num = uebc_pkg::PRESC_NUM_1;
                modulus = uebc_pkg::PRESC_MOD_1;
            end
            default: begin // reserved code falls back to divide by 13
                num = uebc_pkg::PRESC_NUM_1;
                modulus = uebc_pkg::PRESC_MOD_13;
            end
        endcase
        sum = {1'b0, q.acc} + {1'b0, num};
        if (sum >= {1'b0, modulus}) begin // RULE11
            d.acc = 5'(sum - {1'b0, modulus});
            d.tick = 1'b1;
        end else begin
            d.acc = sum[4:0];
            d.tick = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick = q.tick;

endmodule

`default_nettype wire

// >>> uebc_top.sv
// How it works
// RULE1: reset clears both extended control registers to zero.
// RULE2: extended select bit 0 puts the port into extended mode.
// RULE3: loopback bit 4 shared with modem control bit 4; tx feeds rx.
// RULE4: extended loopback: dtr drives dsr and ri, rts drives cts and dcd.
// RULE5: loopback keeps interrupts; modem sources are modem control bits.
// RULE6: loopback cuts serial and infrared receive pins, loops transmit.
// RULE7: loopback holds serial out high, infrared low, unless tx enabled.
// RULE8: transmit-during-loopback bit 5 lets serial output run normally.
// RULE9: loopback cuts four modem status pins, uses modem control low bits.
// RULE10: baud test bit 7 puts baud generator output on terminal-ready pin.
// RULE11: prescaler divides input clock by 13, 1.625 or 1 per select.
// RULE12: lock bit moves non-extended divisor accesses to two scratchpads.
// RULE13: software keeps lock bit zero while extended mode is selected.
// RULE14: bank two reserved register resets zero, reads zero.
// RULE15: transmit level register shows transmit fifo byte count, upper zero.
// RULE16: receive level register shows receive fifo byte count, upper zero.
// RULE17: software reads level three times to get a stable count.
// RULE18: identity register returns module type high, revision low.
// RULE19: line control shadow returns line control, written at offset 03h.
// RULE20: fifo control shadow returns the write-only fifo control register.
// RULE21: reserved extended control bits read zero and do nothing.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module uebc_top #(
    parameter logic [3:0] MODULE_TYPE = uebc_pkg::MODULE_TYPE_DEF,
    parameter logic [3:0] REVISION = uebc_pkg::REVISION_DEF
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [uebc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire uebc_pkg::uebc_pins_s pins_in,
    input wire logic core_sout,
    input wire logic core_irtx,
    input wire uebc_pkg::uebc_levels_s levels,
    output logic sout,
    output logic irtx,
    output logic dtr_n,
    output logic rts_n,
    output logic core_sin,
    output logic core_irrx,
    output uebc_pkg::uebc_modem_s modem,
    output logic extended_mode,
    output logic loopback,
    output logic [15:0] divisor,
    output logic baud_tick,
    output logic [7:0] line_control,
    output logic [7:0] fifo_control
);

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [7:0] ext_one;
        logic [7:0] ext_two;
        logic loop;
        logic [3:0] mc_low;
        logic [7:0] line_control;
        logic [7:0] fifo_control;
        logic [15:0] divisor;
        logic [7:0] scratch_low;
        logic [7:0] scratch_high;
        logic [5:0] s1;
        logic [5:0] s2;
        logic [5:0] s3;
        logic [5:0] pins_f;
        logic [15:0] baud_cnt;
        logic baud_tick;
        logic sout;
        logic irtx;
        logic dtr_n;
        logic rts_n;
        logic core_sin;
        logic core_irrx;
        uebc_pkg::uebc_modem_s modem;
    } uebc_state_s;

    uebc_state_s q;
    uebc_state_s d;
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic presc_tick;
    logic [3:0] idx;
    logic [7:0] wbyte;
    logic [7:0] rd_byte;
    logic hit;
    logic setup;
    logic wr_en;
    logic scratch;
    logic ext;
    logic quiet_tx;
    logic [5:0] agree;
    uebc_pkg::uebc_pins_s pf;

    // divisor locations lead to the scratchpads when locked outside
    // extended mode; read and write decode must agree
    function automatic logic to_scratch(input logic lock, input logic ext_sel);
        to_scratch = lock & ~ext_sel;
    endfunction

    // reset released through two flops so release is clean to clk
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    uebc_prescaler u_presc (
        .clk(clk),
        .rst_n(rst_n),
        .sel(q.ext_two[uebc_pkg::PRESC_LSB+1:uebc_pkg::PRESC_LSB]),
        .tick(presc_tick)
    );

    always_comb begin
        d = q;
        idx = paddr[uebc_pkg::IDX_LSB+3:uebc_pkg::IDX_LSB];
        wbyte = pwdata[7:0];
        setup = psel & ~penable;
        wr_en = psel & penable & q.pready & pwrite & pstrb[0];
        ext = q.ext_one[uebc_pkg::EXT_SEL_BIT]; // RULE2
        scratch = to_scratch(q.ext_two[uebc_pkg::LOCK_BIT], ext);
        pf = q.pins_f;

        // read decode; level counts are sampled live, not frozen
        rd_byte = 8'h00;
        hit = 1'b1;
        case (idx)
            uebc_pkg::IDX_MODULE_IDENTITY: begin
                rd_byte = {MODULE_TYPE, REVISION}; // RULE18
            end
            uebc_pkg::IDX_LC_SHADOW: begin
                rd_byte = q.line_control; // RULE19
            end
            uebc_pkg::IDX_FC_SHADOW: begin
                rd_byte = q.fifo_control; // RULE20
            end
            uebc_pkg::IDX_LINE_CONTROL: begin
                rd_byte = q.line_control;
            end
            uebc_pkg::IDX_EXT_ONE: begin
                rd_byte = q.ext_one; // RULE21
                rd_byte[uebc_pkg::LOOP_BIT] = q.loop;
            end
            uebc_pkg::IDX_BANK2_RSVD: begin
                rd_byte = 8'h00; // RULE14
            end
            uebc_pkg::IDX_EXT_TWO: begin
                rd_byte = q.ext_two; // RULE21
            end
            uebc_pkg::IDX_TX_LEVEL: begin
                rd_byte = {3'h0, levels.tx_count}; // RULE15
            end
            uebc_pkg::IDX_RX_LEVEL: begin
                rd_byte = {3'h0, levels.rx_count}; // RULE16
            end
            uebc_pkg::IDX_MODEM_CONTROL: begin
                rd_byte = {3'h0, q.loop, q.mc_low}; // RULE3
            end
            uebc_pkg::IDX_FIFO_CONTROL: begin
                rd_byte = 8'h00; // write-only location
            end
            uebc_pkg::IDX_DIV_LOW: begin
                rd_byte = scratch ? q.scratch_low : q.divisor[7:0]; // RULE12
            end
            uebc_pkg::IDX_DIV_HIGH: begin
                rd_byte = scratch ? q.scratch_high : q.divisor[15:8]; // RULE12
            end
            default: begin
                hit = 1'b0;
            end
        endcase

        // no wait state: answer prepared in setup, shown in the first access cycle
        d.pready = setup;
        d.pslverr = setup & ~hit;
        d.prdata = setup ? {24'h000000, rd_byte} : 32'h00000000;

        // writes take effect at the access edge only
        if (wr_en) begin
            case (idx)
                uebc_pkg::IDX_LINE_CONTROL: begin
                    d.line_control = wbyte; // RULE19
                end
                uebc_pkg::IDX_EXT_ONE: begin
                    d.ext_one = wbyte & uebc_pkg::EXT_ONE_STORE_MASK; // RULE21
                    d.loop = wbyte[uebc_pkg::LOOP_BIT]; // RULE3
                end
                uebc_pkg::IDX_EXT_TWO: begin
                    d.ext_two = wbyte & uebc_pkg::EXT_TWO_STORE_MASK; // RULE21
                end
                uebc_pkg::IDX_MODEM_CONTROL: begin
                    d.mc_low = wbyte[3:0];
                    d.loop = wbyte[uebc_pkg::LOOP_BIT]; // RULE3
                end
                uebc_pkg::IDX_FIFO_CONTROL: begin
                    d.fifo_control = wbyte; // RULE20
                end
                uebc_pkg::IDX_DIV_LOW: begin
                    if (scratch) begin // RULE12
                        d.scratch_low = wbyte;
                    end else begin
                        d.divisor[7:0] = wbyte;
                    end
                end
                uebc_pkg::IDX_DIV_HIGH: begin
                    if (scratch) begin // RULE12
                        d.scratch_high = wbyte;
                    end else begin
                        d.divisor[15:8] = wbyte;
                    end
                end
                default: begin
                end
            endcase
        end

        // three-stage pin sync; a bit moves once stages two and three agree
        d.s1 = pins_in;
        d.s2 = q.s1;
        d.s3 = q.s2;
        agree = q.s2 ~^ q.s3;
        d.pins_f = (agree & q.s3) | (~agree & q.pins_f);

        // baud generator counts prescaler ticks down from the divisor;
        // a divisor of zero behaves like one
        d.baud_tick = 1'b0;
        if (presc_tick) begin
            if (q.baud_cnt <= 16'h0001) begin
                d.baud_cnt = q.divisor;
                d.baud_tick = 1'b1;
            end else begin
                d.baud_cnt = q.baud_cnt - 16'h0001;
            end
        end

        // receive paths: pins cut off in loopback
        d.core_sin = q.loop ? core_sout : pf.sin; // RULE6
        d.core_irrx = q.loop ? core_irtx : pf.irrx; // RULE6

        // modem status: from pins, or from modem control in loopback;
        // the core's delta logic keeps raising modem interrupts either way
        if (q.loop) begin // RULE9 RULE5
            d.modem.dsr = q.mc_low[uebc_pkg::MC_DTR_BIT];
            d.modem.cts = q.mc_low[uebc_pkg::MC_RTS_BIT];
            if (ext) begin // RULE4
                d.modem.ri = q.mc_low[uebc_pkg::MC_DTR_BIT];
                d.modem.dcd = q.mc_low[uebc_pkg::MC_RTS_BIT];
            end else begin
                d.modem.ri = q.mc_low[uebc_pkg::MC_OUT1_BIT];
                d.modem.dcd = q.mc_low[uebc_pkg::MC_OUT2_BIT];
            end
        end else begin
            d.modem.dsr = ~pf.dsr_n;
            d.modem.cts = ~pf.cts_n;
            d.modem.ri = ~pf.ri_n;
            d.modem.dcd = ~pf.dcd_n;
        end

        // transmit pins idle in loopback unless transmit stays enabled
        quiet_tx = q.loop & ~q.ext_one[uebc_pkg::TDL_BIT]; // RULE8
        d.sout = quiet_tx ? 1'b1 : core_sout; // RULE7
        d.irtx = quiet_tx ? 1'b0 : core_irtx; // RULE7

        // rts, and dtr outside baud test, rest inactive in loopback so the line sees idle
        if (q.ext_one[uebc_pkg::BAUD_TEST_BIT]) begin
            d.dtr_n = q.baud_tick; // RULE10
        end else begin
            d.dtr_n = q.loop | ~q.mc_low[uebc_pkg::MC_DTR_BIT];
        end
        d.rts_n = q.loop | ~q.mc_low[uebc_pkg::MC_RTS_BIT];
    end

    // state register; idle pin levels avoid a false break at start
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.ext_one <= uebc_pkg::EXT_ONE_RST; // RULE1
            q.ext_two <= uebc_pkg::EXT_TWO_RST; // RULE1
            q.mc_low <= uebc_pkg::MC_LOW_RST;
            q.line_control <= uebc_pkg::BYTE_RST;
            q.fifo_control <= uebc_pkg::BYTE_RST;
            q.divisor <= uebc_pkg::DIVISOR_RST;
            q.s1 <= uebc_pkg::PINS_IDLE;
            q.s2 <= uebc_pkg::PINS_IDLE;
            q.s3 <= uebc_pkg::PINS_IDLE;
            q.pins_f <= uebc_pkg::PINS_IDLE;
            q.sout <= 1'b1;
            q.dtr_n <= 1'b1;
            q.rts_n <= 1'b1;
            q.core_sin <= 1'b1;
            q.core_irrx <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // every output straight from the state register
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign sout = q.sout;
    assign irtx = q.irtx;
    assign dtr_n = q.dtr_n;
    assign rts_n = q.rts_n;
    assign core_sin = q.core_sin;
    assign core_irrx = q.core_irrx;
    assign modem = q.modem;
    assign extended_mode = q.ext_one[uebc_pkg::EXT_SEL_BIT];
    assign loopback = q.loop;
    assign divisor = q.divisor;
    assign baud_tick = q.baud_tick;
    assign line_control = q.line_control;
    assign fifo_control = q.fifo_control;

endmodule

`default_nettype wire
